// ### rtl/sdm_defines.svh
// Purpose: shared constants of the storage-data fan-in and control-store addressing
// Assumes: included by bare name from the package and the design files
// Notes: bit 00 of a documented word is the msb of a [15:0] vector
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH

`define SDM_DATA_W 16
`define SDM_DOUT_RST 16'h0000
`define SDM_CSA_W 14
`define SDM_UC_W 32
`define SDM_UC_DEPTH 16384
`define SDM_BT_W 10
`define SDM_BT_AW 8
`define SDM_BT_DEPTH 256
`define SDM_OP_MSB 31
`define SDM_OP_LSB 28
`define SDM_OP_TBJ 4'hF
`define SDM_STABLE_MIN 2
`define SDM_STABLE_W 2
`define SDM_SHIFT_MSB 3

`endif

// ### rtl/sdm_pkg.sv
// Purpose: types shared by the fan-in block and its testbench
// Assumes: sdm_defines.svh is on the include path
// Notes: none
`include "sdm_defines.svh"

package sdm_pkg;
    // source of the memory data selector; one per cycle or none
    typedef enum logic [1:0] {
        SDM_SRC_NONE,
        SDM_SRC_MAIN,
        SDM_SRC_PROT,
        SDM_SRC_DOUT
    } sdm_src_e;

    // decoded micro-command fields steering the datapath
    typedef struct packed {
        sdm_src_e src;
        logic dout_load;
        logic arith_load;
    } sdm_ctl_s;

    // console access to control storage
    typedef struct packed {
        logic rd;
        logic wr;
        logic table_area;
        logic [`SDM_UC_W-1:0] wdata;
    } sdm_con_s;
endpackage

// ### rtl/sdm_mem.sv
// Purpose: single-port synchronous memory with registered read data
// Assumes: one access per enabled cycle
// Notes: read data hold between reads
`timescale 1ns/1ps
`default_nettype none

module sdm_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic core_clk, // clock
    input wire logic en, // access strobe
    input wire logic we, // write when high, else read
    input wire logic [AW-1:0] addr, // word address
    input wire logic [WIDTH-1:0] wdata, // write data
    output logic [WIDTH-1:0] rdata_ff // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array, so it maps onto plain ram
    always_ff @(posedge core_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    // read data come from a register
    always_ff @(posedge core_clk) begin
        if (en && !we) begin
            rdata_ff <= mem[addr];
        end
    end
endmodule

`default_nettype wire

// ### rtl/sdm_core.sv
// Purpose: storage-data fan-in, data-out register and control-store addressing
// Assumes: one clock; microcode sequencer drives the control store address
// Notes: clk_en low freezes every flip-flop
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"

module sdm_core (
    input wire logic core_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire sdm_pkg::sdm_ctl_s ctl, // decoded micro-command fields
    input wire logic [`SDM_DATA_W-1:0] main_rdata, // main storage read data
    input wire logic [`SDM_DATA_W-1:0] prot_rdata, // protection option output
    input wire logic [`SDM_DATA_W-1:0] regfile_data, // data register load value
    input wire logic console_dout_load, // console load strobe
    input wire logic [`SDM_DATA_W-1:0] console_dout_data, // console load value
    input wire logic console_show_dout, // display selects data register
    input wire logic [`SDM_CSA_W-1:0] control_store_address_reg, // sequencer address
    input wire logic fetch_req, // fetch a micro-command
    input wire sdm_pkg::sdm_con_s con, // console store access
    output logic [`SDM_DATA_W-1:0] dout_ff, // data output register
    output logic [`SDM_DATA_W-1:0] arith_input_reg_ff, // arithmetic input register
    output logic [`SDM_DATA_W-1:0] alu_operand_selector_ff, // alu operand from selector
    output logic [`SDM_SHIFT_MSB:0] shift_count_ff, // shift count candidate
    output logic [`SDM_DATA_W-1:0] console_disp_ff, // console data display
    output logic [`SDM_UC_W-1:0] ucmd_ff, // executing micro-command
    output logic ucmd_valid_ff, // micro-command executes this cycle
    output logic table_branch_jump_ff, // table branch taken, pulse
    output logic [`SDM_BT_W-1:0] jump_target_ff, // decoded branch target
    output logic tbj_wait, // table branch held for stable address
    output logic [`SDM_UC_W-1:0] console_rdata_ff, // console read data
    output logic console_rvalid_ff // console read data valid, pulse
);
    import sdm_pkg::*;

    logic [`SDM_DATA_W-1:0] fanin;
    logic [`SDM_DATA_W-1:0] prev_fanin_ff;
    logic [`SDM_STABLE_W-1:0] stable_cnt_ff;
    logic [`SDM_BT_AW-1:0] bt_addr;
    logic [`SDM_UC_W-1:0] uc_rdata;
    logic [`SDM_BT_W-1:0] bt_rdata;
    logic con_busy;
    logic fetch_pend_ff;
    logic is_tbj;
    logic tbj_go;
    logic bt_rd_pend_ff;
    logic con_rd_pend_ff;
    logic con_rd_tab_ff;
    logic uc_en;
    logic uc_we;
    logic bt_en;
    logic bt_we;

    // one source or zero; shared by datapath and display paths
    function automatic logic [`SDM_DATA_W-1:0] fanin_mux(input sdm_src_e src,
        input logic [`SDM_DATA_W-1:0] m, input logic [`SDM_DATA_W-1:0] p,
        input logic [`SDM_DATA_W-1:0] d);
        logic [`SDM_DATA_W-1:0] r;
        r = '0;
        unique case (src)
            SDM_SRC_NONE: r = '0;
            SDM_SRC_MAIN: r = m;
            SDM_SRC_PROT: r = p;
            SDM_SRC_DOUT: r = d;
        endcase
        return r;
    endfunction

    // documented bit n is vector bit 15-n
    function automatic logic dfb(input logic [`SDM_DATA_W-1:0] f, input int n);
        return f[`SDM_DATA_W-1-n];
    endfunction

    // squeeze bits 00-08 and 12 into the low eight table address bits
    function automatic logic [`SDM_BT_AW-1:0] tbj_encode(input logic [`SDM_DATA_W-1:0] f);
        logic [3:0] hi;
        logic [3:0] lo;
        logic [`SDM_BT_AW-1:0] a;
        hi = f[15:12];
        lo = f[11:8];
        a = '0;
        unique case (hi)
            4'h2, 4'h3, 4'hA, 4'hB: a = {2'b00, dfb(f, 0), dfb(f, 3),
                (lo == 4'hB) || (lo >= 4'hC), (lo == 4'hA) || (lo >= 4'hC), dfb(f, 8), dfb(f, 12)};
            4'h6, 4'h7: a = {2'b01, 1'b0, dfb(f, 3), dfb(f, 4), dfb(f, 5), dfb(f, 8), dfb(f, 12)};
            4'hE: a = {2'b10, dfb(f, 4), dfb(f, 5), dfb(f, 6), dfb(f, 7), dfb(f, 8), dfb(f, 12)};
            4'hF: a = {2'b11, dfb(f, 4), dfb(f, 5), dfb(f, 6), dfb(f, 7), dfb(f, 8), dfb(f, 12)};
            default: a = {2'b01, 1'b1, dfb(f, 0), dfb(f, 1), dfb(f, 3), dfb(f, 4), dfb(f, 5)};
        endcase
        return a;
    endfunction

    assign fanin = fanin_mux(ctl.src, main_rdata, prot_rdata, dout_ff);

    // data output register: reset clears, console beats microcode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_ff <= `SDM_DOUT_RST;
        end else if (clk_en) begin
            if (console_dout_load) begin
                dout_ff <= console_dout_data;
            end else if (ctl.dout_load) begin
                dout_ff <= regfile_data;
            end
        end
    end

    // selector fans out to arith, alu operand and shift count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arith_input_reg_ff <= '0;
            alu_operand_selector_ff <= '0;
            shift_count_ff <= '0;
        end else if (clk_en) begin
            if (ctl.arith_load) begin
                arith_input_reg_ff <= fanin;
            end
            alu_operand_selector_ff <= fanin;
            shift_count_ff <= fanin[`SDM_SHIFT_MSB:0];
        end
    end

    // display runs its own copy of the selector so datapath is undisturbed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            console_disp_ff <= '0;
        end else if (clk_en) begin
            if (console_show_dout) begin
                console_disp_ff <= fanin_mux(SDM_SRC_DOUT, main_rdata, prot_rdata, dout_ff);
            end else begin
                console_disp_ff <= '0;
            end
        end
    end

    // count cycles the encoded table address has not changed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_fanin_ff <= '0;
            stable_cnt_ff <= '0;
        end else if (clk_en) begin
            prev_fanin_ff <= fanin;
            if (tbj_encode(fanin) != tbj_encode(prev_fanin_ff)) begin
                stable_cnt_ff <= '0;
            end else if (stable_cnt_ff < `SDM_STABLE_W'(`SDM_STABLE_MIN)) begin
                stable_cnt_ff <= stable_cnt_ff + 1'b1;
            end
        end
    end

    assign con_busy = con.rd || con.wr || con_rd_pend_ff;
    assign is_tbj = ucmd_valid_ff && (ucmd_ff[`SDM_OP_MSB:`SDM_OP_LSB] == `SDM_OP_TBJ);
    // branch waits until the encoded address has held two cycles
    assign tbj_go = is_tbj && !con_busy && (stable_cnt_ff >= `SDM_STABLE_W'(`SDM_STABLE_MIN));
    assign tbj_wait = is_tbj && !tbj_go;

    // microcode store: only the address register addresses it
    assign uc_en = clk_en && ((fetch_req && !con_busy) || ((con.rd || con.wr) && !con.table_area));
    assign uc_we = con.wr && !con.table_area;
    // branch table: address register for console, selector for branches
    assign bt_en = clk_en && (tbj_go || ((con.rd || con.wr) && con.table_area));
    assign bt_we = con.wr && con.table_area;
    assign bt_addr = (con.rd || con.wr) ? control_store_address_reg[`SDM_BT_AW-1:0]
                                        : tbj_encode(fanin);

    // two separate stores
    sdm_mem #(.WIDTH(`SDM_UC_W), .DEPTH(`SDM_UC_DEPTH), .AW(`SDM_CSA_W)) u_ucode (
        .core_clk(core_clk),
        .en(uc_en),
        .we(uc_we),
        .addr(control_store_address_reg),
        .wdata(con.wdata),
        .rdata_ff(uc_rdata)
    );

    // 256 words of 10 bits holding jump targets
    sdm_mem #(.WIDTH(`SDM_BT_W), .DEPTH(`SDM_BT_DEPTH), .AW(`SDM_BT_AW)) u_btab (
        .core_clk(core_clk),
        .en(bt_en),
        .we(bt_we),
        .addr(bt_addr),
        .wdata(con.wdata[`SDM_BT_W-1:0]),
        .rdata_ff(bt_rdata)
    );

    // fetch then execute; console traffic suppresses execution
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_pend_ff <= 1'b0;
            ucmd_ff <= '0;
            ucmd_valid_ff <= 1'b0;
        end else if (clk_en) begin
            fetch_pend_ff <= fetch_req && !con_busy;
            if (fetch_pend_ff && !con_busy) begin
                ucmd_ff <= uc_rdata;
                ucmd_valid_ff <= 1'b1;
            end else if (!tbj_wait || con_busy) begin
                ucmd_valid_ff <= 1'b0;
            end
        end
    end

    // table branch target one cycle after the lookup
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bt_rd_pend_ff <= 1'b0;
            table_branch_jump_ff <= 1'b0;
            jump_target_ff <= '0;
        end else if (clk_en) begin
            bt_rd_pend_ff <= tbj_go;
            table_branch_jump_ff <= bt_rd_pend_ff;
            if (bt_rd_pend_ff) begin
                jump_target_ff <= bt_rdata;
            end
        end
    end

    // console read return, picked from whichever store was read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            con_rd_pend_ff <= 1'b0;
            con_rd_tab_ff <= 1'b0;
            console_rdata_ff <= '0;
            console_rvalid_ff <= 1'b0;
        end else if (clk_en) begin
            con_rd_pend_ff <= con.rd && !con.wr;
            con_rd_tab_ff <= con.table_area;
            console_rvalid_ff <= con_rd_pend_ff;
            if (con_rd_pend_ff) begin
                console_rdata_ff <= con_rd_tab_ff ? {{(`SDM_UC_W-`SDM_BT_W){1'b0}}, bt_rdata} : uc_rdata;
            end
        end
    end
endmodule

`default_nettype wire

// ### testbench/sdm_core_assertions.sv
// Purpose: concurrent checks on the fan-in block ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound onto every sdm_core instance
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"

module sdm_core_assertions (
    input wire logic core_clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic clk_en, // state freeze when low
    input wire sdm_pkg::sdm_ctl_s ctl, // decoded fields
    input wire logic [`SDM_DATA_W-1:0] main_rdata, // main storage data
    input wire logic [`SDM_DATA_W-1:0] regfile_data, // microcode load value
    input wire logic console_dout_load, // console load strobe
    input wire logic [`SDM_DATA_W-1:0] console_dout_data, // console load value
    input wire logic console_show_dout, // display select
    input wire logic fetch_req, // fetch request
    input wire sdm_pkg::sdm_con_s con, // console store access
    input wire logic [`SDM_DATA_W-1:0] dout_ff, // data output register
    input wire logic [`SDM_DATA_W-1:0] arith_input_reg_ff, // arithmetic input
    input wire logic [`SDM_DATA_W-1:0] alu_operand_selector_ff, // alu operand
    input wire logic [`SDM_SHIFT_MSB:0] shift_count_ff, // shift count
    input wire logic [`SDM_DATA_W-1:0] console_disp_ff, // console display
    input wire logic ucmd_valid_ff, // micro-command executes
    input wire logic table_branch_jump_ff, // table branch pulse
    input wire logic console_rvalid_ff // console read valid
);
    import sdm_pkg::*;
    // every check shares the one clock and its reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_rst_clear; $rose(arst_n) |-> dout_ff == 16'h0000; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("data register not clear after reset");
    property p_con_load; clk_en && console_dout_load |=> dout_ff == $past(console_dout_data); endproperty
    a_con_load: assert property (p_con_load) else $error("console load not taken");
    // console strobe must win over the microcode strobe
    property p_uc_load; clk_en && ctl.dout_load && !console_dout_load |=> dout_ff == $past(regfile_data); endproperty
    a_uc_load: assert property (p_uc_load) else $error("microcode load not taken");
    property p_disp; clk_en && console_show_dout |=> console_disp_ff == $past(dout_ff); endproperty
    a_disp: assert property (p_disp) else $error("display does not show data register");
    property p_main; clk_en && ctl.src == SDM_SRC_MAIN |=> alu_operand_selector_ff == $past(main_rdata); endproperty
    a_main: assert property (p_main) else $error("selector main source wrong");
    property p_none; clk_en && ctl.src == SDM_SRC_NONE |=> alu_operand_selector_ff == 16'h0000; endproperty
    a_none: assert property (p_none) else $error("selector not zero without source");
    property p_arith; clk_en && ctl.arith_load && ctl.src == SDM_SRC_DOUT |=> arith_input_reg_ff == $past(dout_ff); endproperty
    a_arith: assert property (p_arith) else $error("arith register misses data register");
    // both registers load from the same selector word at the same edge
    property p_shift; shift_count_ff == alu_operand_selector_ff[3:0]; endproperty
    a_shift: assert property (p_shift) else $error("shift count not selector low bits");
    property p_rvalid; console_rvalid_ff |-> $past(con.rd, 2); endproperty
    a_rvalid: assert property (p_rvalid) else $error("console read valid without read");
    property p_uvalid; $rose(ucmd_valid_ff) |-> $past(fetch_req, 2); endproperty
    a_uvalid: assert property (p_uvalid) else $error("micro-command without fetch");

    c_rvalid: cover property (console_rvalid_ff);
    c_tbj: cover property (table_branch_jump_ff);
    c_both_load: cover property (clk_en && console_dout_load && ctl.dout_load);
endmodule

bind sdm_core sdm_core_assertions u_sdm_core_assertions (.*);
`default_nettype wire

// ### testbench/sdm_seq_model.sv
// Purpose: sequencer stand-in driving store address and fetch requests
// Assumes: bench steers it through go and addr_in
// Notes: address lags addr_in by one cycle
`timescale 1ns/1ps
`default_nettype none

module sdm_seq_model (
    input wire logic core_clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic go, // request one fetch
    input wire logic [13:0] addr_in, // next address
    output logic [13:0] control_store_address_reg, // address to block
    output logic fetch_req // fetch pulse
);
    // registered so outputs move only just after an edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            control_store_address_reg <= 14'h0000;
            fetch_req <= 1'h0;
        end else begin
            control_store_address_reg <= addr_in;
            fetch_req <= go;
        end
    end
endmodule
`default_nettype wire

// ### testbench/sdm_core_tb.sv
// Purpose: self-checking bench for the fan-in block
// Assumes: inputs change 1 ns after each rising edge
// Notes: table branch target worked out by hand for one FX word
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end

module sdm_core_tb;
    import sdm_pkg::*;
    typedef struct packed {sdm_src_e src; logic [15:0] m; logic [15:0] p; logic [15:0] e;} sdm_row_s;
    // dout row relies on 16'h1234 loaded first
    sdm_row_s rows [4] = '{'{SDM_SRC_MAIN, 16'hA5C3, 16'h3C5A, 16'hA5C3}, '{SDM_SRC_PROT, 16'hA5C3, 16'h3C5A, 16'h3C5A},
        '{SDM_SRC_DOUT, 16'hFFFF, 16'hFFFF, 16'h1234}, '{SDM_SRC_NONE, 16'hFFFF, 16'hFFFF, 16'h0000}};
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic clk_en = 1'h1;
    logic console_dout_load = 1'h0;
    logic console_show_dout = 1'h0;
    logic go = 1'h0;
    logic seen = 1'h0;
    logic [15:0] main_rdata = 16'h0000;
    logic [15:0] prot_rdata = 16'h0000;
    logic [15:0] regfile_data = 16'h0000;
    logic [15:0] console_dout_data = 16'h0000;
    logic [13:0] addr_in = 14'h0000;
    sdm_ctl_s ctl = '0;
    sdm_con_s con = '0;
    logic [13:0] control_store_address_reg;
    logic [15:0] dout_ff, arith_input_reg_ff, alu_operand_selector_ff, console_disp_ff;
    logic [31:0] ucmd_ff, console_rdata_ff;
    logic [9:0] jump_target_ff;
    logic [3:0] shift_count_ff;
    logic fetch_req, ucmd_valid_ff, table_branch_jump_ff, tbj_wait, console_rvalid_ff;
    int fail_count = 0;
    int check_count = 0;

    sdm_core u_sdm_core (.*);
    sdm_seq_model u_sdm_seq_model (.core_clk, .arst_n, .go, .addr_in, .control_store_address_reg, .fetch_req);

    always #5 core_clk = ~core_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cyc(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // bounded wait; running out ends the run
    task automatic wait_hi(input string n, ref logic s);
        for (int i = 0; i < 10 && s !== 1'h1; i++) cyc();
        `CHK(n, 1'h1, s)
        if (s !== 1'h1) finish_test();
    endtask

    // one console store access at the sequencer address
    task automatic cacc(input logic rd, input logic area, input logic [31:0] d);
        con = '{rd, !rd, area, d};
        cyc();
        con = '0;
        if (rd) wait_hi("rvalid", console_rvalid_ff);
    endtask

    initial begin
        cyc(8);
        arst_n = 1'h1;
        `CHK("dout_rst", 16'h0000, dout_ff)
        regfile_data = 16'h1234;
        ctl.dout_load = 1'h1;
        cyc();
        ctl.dout_load = 1'h0;
        `CHK("dout_uc", 16'h1234, dout_ff)
        foreach (rows[i]) begin
            ctl = '{rows[i].src, 1'h0, 1'h1};
            main_rdata = rows[i].m;
            prot_rdata = rows[i].p;
            cyc();
            `CHK("alu_sel", rows[i].e, alu_operand_selector_ff)
            `CHK("arith", rows[i].e, arith_input_reg_ff)
            `CHK("shift", rows[i].e[3:0], shift_count_ff)
        end
        // both strobes at once: console value must win
        ctl = '{SDM_SRC_NONE, 1'h1, 1'h0};
        console_dout_load = 1'h1;
        console_dout_data = 16'hBEEF;
        console_show_dout = 1'h1;
        cyc();
        ctl.dout_load = 1'h0;
        `CHK("dout_con", 16'hBEEF, dout_ff)
        clk_en = 1'h0;
        console_dout_data = 16'h5555;
        cyc();
        `CHK("dout_frozen", 16'hBEEF, dout_ff)
        clk_en = 1'h1;
        console_dout_load = 1'h0;
        cyc();
        `CHK("disp", 16'hBEEF, console_disp_ff)
        console_show_dout = 1'h0;
        cyc();
        `CHK("disp_off", 16'h0000, console_disp_ff)
        // same address in both areas must not alias
        addr_in = 14'h00FF;
        cyc();
        cacc(1'h0, 1'h0, 32'h1234_5678);
        cacc(1'h0, 1'h1, 32'h0000_02AB);
        cacc(1'h1, 1'h1, 32'h0000_0000);
        `CHK("tbl_rd", 10'h2AB, console_rdata_ff[9:0])
        cacc(1'h1, 1'h0, 32'h0000_0000);
        `CHK("uc_rd", 32'h1234_5678, console_rdata_ff)
        go = 1'h1;
        cyc();
        go = 1'h0;
        wait_hi("ucmd_valid", ucmd_valid_ff);
        `CHK("ucmd", 32'h1234_5678, ucmd_ff)
        // fetch meeting a console read is refused
        go = 1'h1;
        cyc();
        go = 1'h0;
        con.rd = 1'h1;
        cyc();
        con = '0;
        for (int i = 0; i < 4; i++) begin
            cyc();
            if (ucmd_valid_ff === 1'h1) seen = 1'h1;
        end
        `CHK("refused", 1'h0, seen)
        // selector FA88 with FX row encodes table address EB
        addr_in = 14'h00EB;
        cyc();
        cacc(1'h0, 1'h1, 32'h0000_03C1);
        cacc(1'h0, 1'h0, 32'hF000_0000);
        // address changes as the fetch starts, so the branch must wait
        go = 1'h1;
        cyc();
        go = 1'h0;
        ctl = '{SDM_SRC_MAIN, 1'h0, 1'h0};
        main_rdata = 16'hFA88;
        cyc(2);
        `CHK("tbj_wait", 1'h1, tbj_wait)
        wait_hi("tbj", table_branch_jump_ff);
        `CHK("target", 10'h3C1, jump_target_ff)
        `CHK("tbj_wait_off", 1'h0, tbj_wait)
        arst_n = 1'h0;
        cyc();
        `CHK("dout_rst2", 16'h0000, dout_ff)
        arst_n = 1'h1;
        cyc();
        finish_test();
    end
endmodule
`default_nettype wire
